// ==== src/puio_top.sv ====
// What this block does
// R01 - A rising edge on the direction input selects infuse and a falling edge selects refill.
// R02 - A falling edge on the event trigger input fires the next program event.
// R03 - In toggle mode each falling edge on the footswitch flips run and stop.
// R04 - The footswitch can also start on one edge and stop on the opposite one.
// R05 - The trigger output is low after reset and set by program or serial command.
// R06 - The sync output rises at each infuse start and falls at each refill start.
// R07 - The direction output is high while refilling and low while infusing.
// R08 - The run output is active low, low exactly while running.
// R09 - Connector pulses should last at least a tenth of a second on both sides; this block enforces no minimum and does not stretch its outputs.
// R10 - Each input is synchronised and edge-detected so one edge gives one action.
`timescale 1ns/1ps
module puio_top
  import puio_pkg::*;
#(
  parameter int EVCNT_W = 8
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Connector lines.
  input  wire puio_in_s    pins_in,
  output puio_out_s        pins_out,
  // Program sequencer side.
  input  wire logic        prog_trig_we,
  input  wire logic        prog_trig_val,
  output logic             prog_event,
  // AXI4-Lite write address.
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  default clocking cb_main @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  initial begin
    if (EVCNT_W < 1 || EVCNT_W > 24) begin
      $error("puio_top event counter width must be 1 to 24");
    end
  end

  puio_edge_s dir_e;
  puio_edge_s trg_e;
  puio_edge_s fsw_e;

  puio_edge u_dir (
    .aclk    (aclk),
    .aresetn (aresetn),
    .line    (pins_in.dir_in),
    .edges   (dir_e)
  );

  puio_edge u_trg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .line    (pins_in.trig_in),
    .edges   (trg_e)
  );

  puio_edge u_fsw (
    .aclk    (aclk),
    .aresetn (aresetn),
    .line    (pins_in.fsw_in),
    .edges   (fsw_e)
  );

  // State and registers.
  logic               running;
  logic               refill;
  logic               trig_lvl;
  logic [31:0]        ctrl;
  logic [EVCNT_W-1:0] evcnt;

  // Write channel capture; address and data may arrive in either order.
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire wr_fire  = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ctrl  = wr_fire & (aw_addr == REG_CTRL);
  wire wr_cmd   = wr_fire & (aw_addr == REG_CMD);
  wire wr_ok    = (aw_addr == REG_CTRL) | (aw_addr == REG_CMD)
                | (aw_addr == REG_STATUS);

  wire cmd_run  = wr_cmd & w_strb[0] & w_data[CMD_RUN_BIT];
  wire cmd_stop = wr_cmd & w_strb[0] & w_data[CMD_STOP_BIT];
  wire cmd_inf  = wr_cmd & w_strb[0] & w_data[CMD_INF_BIT];
  wire cmd_ref  = wr_cmd & w_strb[0] & w_data[CMD_REF_BIT];

  wire puio_fs_mode_e fs_mode =
    puio_fs_mode_e'(ctrl[CTRL_FS_MODE_LSB +: 2]);

  // Footswitch start and stop requests per mode.
  wire fs_toggle = (fs_mode == PUIO_FS_TOGGLE) & fsw_e.fall; // R03
  wire fs_start  = ((fs_mode == PUIO_FS_RISE_RUN) & fsw_e.rise)
                 | ((fs_mode == PUIO_FS_FALL_RUN) & fsw_e.fall); // R04
  wire fs_stop   = ((fs_mode == PUIO_FS_RISE_RUN) & fsw_e.fall)
                 | ((fs_mode == PUIO_FS_FALL_RUN) & fsw_e.rise); // R04

  // Pin edges take priority over software commands in the same cycle,
  // since an outside instrument has no way to retry.
  wire next_running = fs_toggle ? ~running :
                      fs_start  ? 1'b1 :
                      fs_stop   ? 1'b0 :
                      cmd_run   ? 1'b1 :
                      cmd_stop  ? 1'b0 : running;

  wire next_refill  = dir_e.rise ? 1'b0 :
                      dir_e.fall ? 1'b1 :
                      cmd_inf    ? 1'b0 :
                      cmd_ref    ? 1'b1 : refill; // R01

  // Program step wins over a serial write in the same cycle.
  wire next_trig    = prog_trig_we ? prog_trig_val :
                      (wr_ctrl & w_strb[0]) ? w_data[CTRL_TRIG_BIT] :
                      trig_lvl; // R05

  wire [31:0] next_ctrl = wr_ctrl ?
    {ctrl[31:8], (w_strb[0] ? w_data[7:0] : ctrl[7:0])} : ctrl;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running <= 1'b0;
      refill  <= 1'b0;
      trig_lvl <= 1'b0; // R05
      ctrl    <= CTRL_RESET;
      evcnt   <= '0;
    end else begin
      running <= next_running;
      refill  <= next_refill;
      trig_lvl <= next_trig;
      ctrl    <= {next_ctrl[31:5], next_trig, next_ctrl[3:0]};
      evcnt   <= evcnt + EVCNT_W'(trg_e.fall);
    end
  end

  // Outputs straight from flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_out   <= '{trig_out: 1'b0, sync_out: 1'b1,
                      dir_out: 1'b0, run_n: 1'b1};
      prog_event <= 1'b0;
    end else begin
      pins_out.trig_out <= next_trig; // R05
      pins_out.sync_out <= ~next_refill; // R06
      pins_out.dir_out  <= next_refill; // R07
      pins_out.run_n    <= ~next_running; // R08
      prog_event        <= trg_e.fall; // R02
    end
  end

  // AXI4-Lite write path.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path.
  wire [3:0]  rd_addr = {s_axi_araddr[3:2], 2'b00};
  wire [23:0] evcnt_word  = 24'(evcnt);
  wire [31:0] status_word = {evcnt_word, 5'h00, trig_lvl, refill, running};
  wire        rd_ok = (rd_addr == REG_CTRL) | (rd_addr == REG_STATUS)
                    | (rd_addr == REG_CMD);
  wire [31:0] rd_word = (rd_addr == REG_CTRL)   ? ctrl :
                        (rd_addr == REG_STATUS) ? status_word : 32'h0;
  wire        ar_take = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= AXI_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks.
  sequence s_dir_rise;
    dir_e.rise;
  endsequence

  sequence s_dir_fall;
    dir_e.fall;
  endsequence

  sequence s_fs_stop;
    fs_stop;
  endsequence

  // One low sample is all the logic needs; the long recommended pulse is
  // margin for slow outside equipment, not a limit of this block.
  sequence s_trig_low2;
    $fell(pins_in.trig_in) ##1 !pins_in.trig_in;
  endsequence

  chk_dir_infuse: assert property ( // R01
    s_dir_rise |=> !refill)
    else $error("direction rise did not select infuse");

  chk_dir_refill: assert property ( // R01
    s_dir_fall |=> refill)
    else $error("direction fall did not select refill");

  chk_event_fire: assert property ( // R02
    trg_e.fall |=> prog_event && evcnt == $past(evcnt) + 1'b1)
    else $error("trigger fall did not fire one event");

  chk_fs_toggle: assert property ( // R03
    fs_toggle |=> running != $past(running))
    else $error("footswitch toggle did not flip run state");

  chk_fs_level: assert property ( // R04
    fs_start |=> running ##1 !pins_out.run_n)
    else $error("footswitch start did not start the pump");

  chk_fs_stop: assert property ( // R04
    s_fs_stop |=> !running && pins_out.run_n)
    else $error("footswitch stop did not stop the pump");

  chk_trig_prog: assert property ( // R05
    prog_trig_we |=> pins_out.trig_out == $past(prog_trig_val))
    else $error("program step did not set trigger output");

  chk_trig_serial: assert property ( // R05
    wr_ctrl && w_strb[0] && !prog_trig_we
      |=> pins_out.trig_out == $past(w_data[CTRL_TRIG_BIT]))
    else $error("serial write did not set trigger output");

  chk_sync_dir: assert property ( // R06
    $rose(refill) |-> $fell(pins_out.sync_out) && pins_out.dir_out)
    else $error("sync did not fall at refill start");

  chk_sync_rise: assert property ( // R06
    $fell(refill) |-> $rose(pins_out.sync_out) && !pins_out.dir_out)
    else $error("sync did not rise at infuse start");

  chk_dir_out: assert property ( // R07
    pins_out.dir_out == refill)
    else $error("direction output disagrees with state");

  chk_run_low: assert property ( // R08
    pins_out.run_n == !running)
    else $error("run output disagrees with run state");

  chk_pulse_seen: assert property ( // R09
    s_trig_low2 |-> ##1 trg_e.fall)
    else $error("short trigger pulse was not detected");

  chk_one_edge: assert property ( // R10
    !$past(trg_e.fall) |-> !prog_event && evcnt == $past(evcnt))
    else $error("event fired without a trigger edge");

endmodule

// ==== shared/puio_pkg.sv ====
package puio_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CMD    = 4'h8;

  // Control register fields.
  localparam int CTRL_FS_MODE_LSB = 0;
  localparam int CTRL_TRIG_BIT    = 4;

  // Command register fields, write-one pulses.
  localparam int CMD_RUN_BIT  = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_INF_BIT  = 2;
  localparam int CMD_REF_BIT  = 3;

  // Status register fields.
  localparam int ST_RUN_BIT    = 0;
  localparam int ST_REFILL_BIT = 1;
  localparam int ST_TRIG_BIT   = 2;
  localparam int ST_EVCNT_LSB  = 8;

  localparam logic [31:0] CTRL_RESET = 32'h0;

  // Recommended least pulse on the connector lines.
  localparam int  MIN_PULSE_MS   = 100;
  localparam int  CLK_MHZ        = 100;
  localparam int  MIN_PULSE_CYC  = MIN_PULSE_MS * 1000 * CLK_MHZ;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PUIO_FS_TOGGLE,
    PUIO_FS_RISE_RUN,
    PUIO_FS_FALL_RUN,
    PUIO_FS_RSVD
  } puio_fs_mode_e;

  typedef struct packed {
    logic dir_in;
    logic trig_in;
    logic fsw_in;
  } puio_in_s;

  typedef struct packed {
    logic trig_out;
    logic sync_out;
    logic dir_out;
    logic run_n;
  } puio_out_s;

  typedef struct packed {
    logic rise;
    logic fall;
  } puio_edge_s;

endpackage

// ==== src/puio_edge.sv ====
`timescale 1ns/1ps
module puio_edge
  import puio_pkg::*;
#(
  parameter int STAGES = 2
) (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Raw line and its edges.
  input  wire logic       line,
  output puio_edge_s      edges
);

  initial begin
    if (STAGES < 2) begin
      $error("puio_edge needs at least two synchroniser stages");
    end
  end

  logic [STAGES-1:0] sync;
  logic              last;

  // Lines idle high through their pull-ups, so reset to one avoids a false
  // rising edge at release.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync <= '1;
      last <= 1'b1;
    end else begin
      sync <= {sync[STAGES-2:0], line}; // R09 R10
      last <= sync[STAGES-1];
    end
  end

  assign edges.rise = sync[STAGES-1] & ~last; // R10
  assign edges.fall = ~sync[STAGES-1] & last; // R10

endmodule

// ==== tb/puio_instr.sv ====
`timescale 1ns/1ps
// Outside instrument on the connector. Lines idle high through the
// pull-ups, and a new level goes out only after the previous one has
// stood HOLD cycles, so no pulse is shorter than the receiver can trust.
module puio_instr
  import puio_pkg::*;
#(
  parameter int HOLD = 12
) (
  // Clock.
  input  wire logic     aclk,
  // Requested and driven levels.
  input  wire puio_in_s want,
  output puio_in_s      pins,
  output logic          busy
);
  int cnt = 0;

  initial pins = 3'b111;
  assign busy = (cnt != 0) || (want !== pins);

  always @(posedge aclk) begin
    if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (want !== pins) begin
      pins <= want;
      cnt  <= HOLD;
    end
  end
endmodule

// ==== tb/test_pump_user_io_control.sv ====
`timescale 1ns/1ps
module test_pump_user_io_control
  import puio_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  puio_in_s    want = 3'b111;
  puio_in_s    pins_in;
  puio_out_s   pins_out;
  logic        trig_we = 1'b0;
  logic        trig_val = 1'b0;
  logic        prog_event;
  logic        busy;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  rs;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n_ev = 0;
  // Row: footswitch mode, line levels, then sync, direction and run_n.
  logic [7:0]  rows [15] = '{8'h34, 8'h3c, 8'h1a, 8'h13, 8'h3d, 8'h2d,
                             8'h3d, 8'h75, 8'h7c, 8'h75, 8'hbd, 8'hb4,
                             8'hbd, 8'hf5, 8'hfd};

  initial forever #5 aclk = ~aclk;

  puio_instr #(.HOLD(12)) i_puio_instr (.aclk(aclk), .want(want),
    .pins(pins_in), .busy(busy));

  puio_top i_puio_top (.aclk(aclk), .aresetn(aresetn), .pins_in(pins_in),
    .pins_out(pins_out), .prog_trig_we(trig_we), .prog_trig_val(trig_val),
    .prog_event(prog_event), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  always @(posedge aclk) begin
    if (prog_event === 1'b1) begin
      n_ev <= n_ev + 1;
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic rdr(input logic [3:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // The line settles through the synchronisers before outputs are judged.
  task automatic drive(input puio_in_s v);
    want <= v;
    @(posedge aclk);
    while (busy) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    do_reset();
    chk(pins_out, 4'b0101, "reset levels");
    for (int i = 0; i < 15; i++) begin
      wr(REG_CTRL, {30'h0, rows[i][7:6]});
      drive(rows[i][5:3]);
      chk(pins_out, {1'b0, rows[i][2:0]}, "pin row");
    end
    chk(n_ev, 1, "event pulses");
    rdr(REG_STATUS);
    chk(rd, 32'h100, "status after rows");
    $display("test pin rows done");
    trig_we  <= 1'b1;
    trig_val <= 1'b1;
    @(posedge aclk);
    trig_we <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(pins_out.trig_out, 1'b1, "program trigger");
    rdr(REG_CTRL);
    chk(rd, 32'h13, "control readback");
    wr(REG_CTRL, 32'h0);
    chk(pins_out.trig_out, 1'b0, "serial trigger");
    $display("test trigger done");
    wr(REG_CMD, 32'h9);
    chk(rs, AXI_OKAY, "command response");
    chk(pins_out[2:0], 3'b010, "run and refill");
    rdr(REG_STATUS);
    chk(rd, 32'h103, "status run refill");
    wr(REG_CMD, 32'h6);
    chk(pins_out[2:0], 3'b101, "stop and infuse");
    wr(REG_CMD, 32'h9);
    chk(pins_out[2:0], 3'b010, "run and refill again");
    wr(REG_STATUS, 32'h0);
    chk(rs, AXI_OKAY, "status write response");
    chk(pins_out[2:0], 3'b010, "status write ignored");
    rdr(REG_CMD);
    chk(rs, AXI_OKAY, "command read response");
    chk(rd, 32'h0, "command reads zero");
    rdr(4'hc);
    chk(rs, AXI_SLVERR, "unmapped response");
    chk(rd, 32'h0, "unmapped data");
    wr(4'hc, 32'h1);
    chk(rs, AXI_SLVERR, "unmapped write");
    chk(pins_out[2:0], 3'b010, "unmapped write ignored");
    $display("test commands done");
    // A second reset from the refilling, running state.
    do_reset();
    chk(pins_out, 4'b0101, "second reset");
    $display("test reset done");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("unexpected at %0t: timeout", $time);
    close_out();
  end
endmodule
